// ==== core/iopm_ports.sv ====
// Design: port configuration registers, pin muxing, data port and reset-pattern drive
`timescale 1ns/100ps
`default_nettype none

// Operation
// - High address pins feed logic, optionally strobe-latched
// - Memory-decode port inputs count as address inputs
// - Data port mode disables I/O, joins bus
// - Port E pins usable as JTAG interface
// - Reset pattern only supported host, during reset
// - Drive pattern on F/G when reset, no cycle
// - After reset F/G return to data port
// - Config registers host readable and writable
// - Register bit n controls pin n
// - All configuration registers reset to zero
// - Mode bit 0 host I/O, 1 address out
// - Direction 1 output, 0 input, default input
// - Port D direction uses low four bits
// - Open-drain bit 1, default push-pull
// - Slew bit 1 fast, default slow
// - Open-drain on A,B,D,E,G; slew on C,F
// - Data-in reads live pin levels
// - Data-out stored, drives, reads back
module iopm_ports #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire  logic                   clk_i,
   input  wire  logic                   rst_i,
   // Host register access in the I/O select space
   input  wire  logic                   io_sel_i,
   input  wire  logic                   rd_i,
   input  wire  logic                   wr_i,
   input  wire  logic [ADDR_W-1:0]      addr_i,
   input  wire  logic [7:0]             wdata_i,
   output logic       [7:0]             rdata_o,
   // Host data bus and mode straps
   input  wire  logic                   nonmux_bus_i,
   input  wire  logic                   reset_mode_en_i,
   input  wire  logic                   bus_cycle_i,
   input  wire  logic [15:0]            reset_pattern_i,
   input  wire  logic [15:0]            host_data_out_i,
   input  wire  logic                   host_data_oe_i,
   output logic       [15:0]            host_data_bus_o,
   // Address strobe and latched address
   input  wire  logic                   address_strobe_input_i,
   input  wire  logic                   strobe_latch_en_i,
   input  wire  logic [15:0]            latched_addr_i,
   input  wire  logic [7:0]             addr_in_sel_i,
   output logic       [7:0]             logic_addr_in_o,
   // Programmable logic output enable terms, per port
   input  wire  logic [7*8-1:0]         pld_oe_i,
   // JTAG on port E
   input  wire  logic                   jtag_en_i,
   input  wire  logic                   jtag_tdo_i,
   output logic       [3:0]             jtag_in_o,
   // Pins: input, output, enable (low = driving), slew
   input  wire  logic [7*8-1:0]         pin_i,
   output logic       [7*8-1:0]         pin_o,
   output logic       [7*8-1:0]         pin_oe_n_o,
   output logic       [7*8-1:0]         pin_fast_slew_o
);
   localparam int NP = iopm_pkg::NUM_PORTS;

   // Address bits 7:4 pick the port, so a narrower bus cannot reach every register
   if (ADDR_W < 8) begin : g_addr_w_check
      $error("ADDR_W must be at least 8");
   end

   // ***************************************************************
   // Register file
   // ***************************************************************
   logic [7:0] mode_r [NP];
   logic [7:0] dir_r  [NP];
   logic [7:0] drv_r  [NP];
   logic [7:0] dout_r [NP];
   logic [7:0] mode_nxt [NP];
   logic [7:0] dir_nxt  [NP];
   logic [7:0] drv_nxt  [NP];
   logic [7:0] dout_nxt [NP];

   function automatic logic [7:0] port_mask(input int p);
      return (p == iopm_pkg::PORT_D) ? iopm_pkg::PORT_D_MASK : 8'hFF;
   endfunction : port_mask

   function automatic logic has_mode(input int p);
      return (p >= iopm_pkg::PORT_E);
   endfunction : has_mode

   logic [7:0] reg_ofs;
   int         port_idx;
   assign reg_ofs  = addr_i[7:0] & iopm_pkg::OFS_REG_MASK;
   assign port_idx = int'(addr_i[7:4]);

   always_comb begin
      for (int p = 0; p < NP; p++) begin
         mode_nxt[p] = mode_r[p];
         dir_nxt[p]  = dir_r[p];
         drv_nxt[p]  = drv_r[p];
         dout_nxt[p] = dout_r[p];
         if (io_sel_i && wr_i && port_idx == p) begin
            unique case (reg_ofs)
               iopm_pkg::OFS_MODE_SEL:  if (has_mode(p)) mode_nxt[p] = wdata_i;
               iopm_pkg::OFS_DIRECTION: dir_nxt[p] = wdata_i & port_mask(p);
               iopm_pkg::OFS_DRIVE:     drv_nxt[p] = wdata_i & port_mask(p);
               iopm_pkg::OFS_DATA_OUT:  dout_nxt[p] = wdata_i & port_mask(p);
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int p = 0; p < NP; p++) begin
            mode_r[p] <= iopm_pkg::CFG_RESET;
            dir_r[p]  <= iopm_pkg::CFG_RESET;
            drv_r[p]  <= iopm_pkg::CFG_RESET;
            dout_r[p] <= iopm_pkg::CFG_RESET;
         end
      end else begin
         for (int p = 0; p < NP; p++) begin
            mode_r[p] <= mode_nxt[p];
            dir_r[p]  <= dir_nxt[p];
            drv_r[p]  <= drv_nxt[p];
            dout_r[p] <= dout_nxt[p];
         end
      end
   end

   // ***************************************************************
   // Reset-pattern state
   // ***************************************************************
   // Reset holds the pattern drive; the first clock after release leaves it.
   iopm_pkg::iopm_state_type state_r;
   iopm_pkg::iopm_state_type state_nxt;
   logic                     rst_drive;

   always_comb begin
      state_nxt = iopm_pkg::IOPM_RUN;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= iopm_pkg::IOPM_RESET_DRIVE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Pattern is driven only while reset is actually asserted
   assign rst_drive = reset_mode_en_i && rst_i && !bus_cycle_i
                      && state_r == iopm_pkg::IOPM_RESET_DRIVE;

   // ***************************************************************
   // Pin drive
   // ***************************************************************
   logic       data_port;
   logic [7:0] addr_lo;
   logic [7:0] addr_hi;
   assign data_port = nonmux_bus_i;
   assign addr_lo   = latched_addr_i[7:0];
   assign addr_hi   = latched_addr_i[15:8];

   always_comb begin
      for (int p = 0; p < NP; p++) begin
         for (int b = 0; b < 8; b++) begin
            logic       drv_val;
            logic       drv_en;
            logic       dedicated;
            logic [7:0] pmask;
            drv_val   = 1'b0;
            drv_en    = 1'b0;
            dedicated = 1'b0;
            pmask     = port_mask(p);
            if (has_mode(p) && mode_r[p][b]) begin
               drv_val = (p == iopm_pkg::PORT_G) ? addr_hi[b] : addr_lo[b];
               drv_en  = dir_r[p][b] || pld_oe_i[p*8+b];
            end else begin
               drv_val = dout_r[p][b];
               drv_en  = (dir_r[p][b] || pld_oe_i[p*8+b]) && pmask[b];
            end
            if (p == iopm_pkg::PORT_E && jtag_en_i && b < 4) begin
               drv_val   = jtag_tdo_i;
               drv_en    = (b == 3);
               dedicated = 1'b1;
            end
            if ((p == iopm_pkg::PORT_F || p == iopm_pkg::PORT_G) && data_port) begin
               drv_val   = host_data_out_i[(p - iopm_pkg::PORT_F)*8+b];
               drv_en    = host_data_oe_i;
               dedicated = 1'b1;
            end
            if ((p == iopm_pkg::PORT_F || p == iopm_pkg::PORT_G) && rst_drive) begin
               drv_val   = reset_pattern_i[(p - iopm_pkg::PORT_F)*8+b];
               drv_en    = 1'b1;
               dedicated = 1'b1;
            end
            // Open drain: drive only the low level, the pull-up makes the high.
            // Dedicated functions bypass it, or a data bus high would be lost.
            if (p != iopm_pkg::PORT_C && p != iopm_pkg::PORT_F && drv_r[p][b] && drv_val
                && !dedicated) begin
               drv_en = 1'b0;
            end
            pin_o[p*8+b]      = drv_val;
            pin_oe_n_o[p*8+b] = !drv_en;
            pin_fast_slew_o[p*8+b] = (p == iopm_pkg::PORT_C || p == iopm_pkg::PORT_F)
                                     && drv_r[p][b];
         end
      end
   end

   // ***************************************************************
   // Input paths
   // ***************************************************************
   logic [7:0] addr_in_r;
   logic [7:0] addr_in_nxt;
   logic [7:0] addr_live;
   logic [15:0] host_in_r;
   logic [15:0] host_in_nxt;

   // Address inputs taken from port F; decode terms select which pins count
   assign addr_live = pin_i[iopm_pkg::PORT_F*8 +: 8] & addr_in_sel_i;

   always_comb begin
      addr_in_nxt = addr_in_r;
      if (address_strobe_input_i) addr_in_nxt = addr_live;
      host_in_nxt = {pin_i[iopm_pkg::PORT_G*8 +: 8], pin_i[iopm_pkg::PORT_F*8 +: 8]};
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_in_r <= 8'h00;
         host_in_r <= 16'h0000;
      end else begin
         addr_in_r <= addr_in_nxt;
         host_in_r <= host_in_nxt;
      end
   end

   assign logic_addr_in_o = strobe_latch_en_i ? addr_in_r : addr_live;
   assign host_data_bus_o = data_port ? host_in_r : 16'h0000;
   assign jtag_in_o       = jtag_en_i ? pin_i[iopm_pkg::PORT_E*8 +: 4] : 4'h0;

   // ***************************************************************
   // Register read
   // ***************************************************************
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   always_comb begin
      rdata_nxt = 8'h00;
      if (io_sel_i && rd_i && port_idx < NP) begin
         unique case (reg_ofs)
            iopm_pkg::OFS_DATA_IN:   rdata_nxt = pin_i[port_idx*8 +: 8] & port_mask(port_idx);
            iopm_pkg::OFS_DATA_OUT:  rdata_nxt = dout_r[port_idx];
            iopm_pkg::OFS_MODE_SEL:  rdata_nxt = has_mode(port_idx) ? mode_r[port_idx] : 8'h00;
            iopm_pkg::OFS_DIRECTION: rdata_nxt = dir_r[port_idx];
            iopm_pkg::OFS_DRIVE:     rdata_nxt = drv_r[port_idx];
            default:                 rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end
   assign rdata_o = rdata_r;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   property p_dir_reset;
      @(posedge clk_i) $fell(rst_i) |-> dir_r[0] == 8'h00 && mode_r[6] == 8'h00;
   endproperty
   a_dir_reset: assert property (p_dir_reset) else $error("config not zero after reset");

   property p_d_upper;
      @(posedge clk_i) disable iff (rst_i) (dir_r[3] & 8'hF0) == 8'h00 && (drv_r[3] & 8'hF0) == 8'h00;
   endproperty
   a_d_upper: assert property (p_d_upper) else $error("port D upper bits set");

   property p_dir_write;
      @(posedge clk_i) disable iff (rst_i)
         io_sel_i && wr_i && addr_i[7:0] == iopm_pkg::OFS_DIRECTION |=> dir_r[0] == $past(wdata_i);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write lost");

   property p_input_hiz;
      @(posedge clk_i) disable iff (rst_i)
         dir_r[0] == 8'h00 && pld_oe_i[7:0] == 8'h00 |-> pin_oe_n_o[7:0] == 8'hFF;
   endproperty
   a_input_hiz: assert property (p_input_hiz) else $error("input pin driven");

   property p_slew;
      @(posedge clk_i) disable iff (rst_i) pin_fast_slew_o[7:0] == 8'h00 && pin_fast_slew_o[23:16] == drv_r[2];
   endproperty
   a_slew: assert property (p_slew) else $error("slew select wrong");

   property p_no_pattern_after;
      @(posedge clk_i) disable iff (rst_i) !rst_drive;
   endproperty
   a_no_pattern_after: assert property (p_no_pattern_after) else $error("pattern outside reset");

   property p_din_read;
      @(posedge clk_i) disable iff (rst_i)
         io_sel_i && rd_i && addr_i[7:0] == iopm_pkg::OFS_DATA_IN |=> rdata_o == $past(pin_i[7:0]);
   endproperty
   a_din_read: assert property (p_din_read) else $error("data-in read wrong");

   property p_dout_drive;
      @(posedge clk_i) disable iff (rst_i)
         dir_r[1] == 8'hFF && drv_r[1] == 8'h00 |-> pin_o[15:8] == dout_r[1] && pin_oe_n_o[15:8] == 8'h00;
   endproperty
   a_dout_drive: assert property (p_dout_drive) else $error("data-out not driven");

   property p_jtag_tdo;
      @(posedge clk_i) disable iff (rst_i)
         jtag_en_i |-> pin_oe_n_o[35] == 1'b0 && pin_o[35] == jtag_tdo_i;
   endproperty
   a_jtag_tdo: assert property (p_jtag_tdo) else $error("jtag output pin wrong");

   property p_data_port;
      @(posedge clk_i) disable iff (rst_i)
         nonmux_bus_i && host_data_oe_i |-> pin_oe_n_o[55:40] == 16'h0000 && pin_o[55:40] == host_data_out_i;
   endproperty
   a_data_port: assert property (p_data_port) else $error("data port not driven");

   property p_reset_pattern;
      @(posedge clk_i)
         rst_i && reset_mode_en_i && !bus_cycle_i |-> pin_oe_n_o[55:40] == 16'h0000 && pin_o[55:40] == reset_pattern_i;
   endproperty
   a_reset_pattern: assert property (p_reset_pattern) else $error("reset pattern not driven");

   property p_addr_out;
      @(posedge clk_i) disable iff (rst_i)
         mode_r[6] == 8'hFF && dir_r[6] == 8'hFF && drv_r[6] == 8'h00 && !nonmux_bus_i
         |-> pin_o[55:48] == latched_addr_i[15:8] && pin_oe_n_o[55:48] == 8'h00;
   endproperty
   a_addr_out: assert property (p_addr_out) else $error("address out wrong");

   c_write: cover property (@(posedge clk_i) io_sel_i && wr_i);
   c_read:  cover property (@(posedge clk_i) io_sel_i && rd_i ##1 rdata_o != 8'h00);
   c_dport: cover property (@(posedge clk_i) nonmux_bus_i && host_data_oe_i);
   c_pattern: cover property (@(posedge clk_i) rst_drive);
endmodule : iopm_ports

`default_nettype wire

// ==== shared/iopm_pkg.sv ====
// Package: register map, port indices and modes for the I/O port configuration block
package iopm_pkg;
   // ***************************************************************
   // Register offsets within the I/O register select space
   // ***************************************************************
   localparam logic [7:0] OFS_DATA_IN   = 8'h00;
   localparam logic [7:0] OFS_DATA_OUT  = 8'h04;
   localparam logic [7:0] OFS_DIRECTION = 8'h06;
   localparam logic [7:0] OFS_DRIVE     = 8'h08;
   localparam logic [7:0] OFS_MODE_SEL  = 8'h02;
   localparam logic [7:0] OFS_PORT_STEP = 8'h10;
   localparam logic [7:0] OFS_REG_MASK  = 8'h0F;

   // ***************************************************************
   // Ports and reset values
   // ***************************************************************
   localparam int          NUM_PORTS    = 7;
   localparam int          PORT_A       = 0;
   localparam int          PORT_B       = 1;
   localparam int          PORT_C       = 2;
   localparam int          PORT_D       = 3;
   localparam int          PORT_E       = 4;
   localparam int          PORT_F       = 5;
   localparam int          PORT_G       = 6;
   localparam logic [7:0]  CFG_RESET    = 8'h00;
   localparam logic [7:0]  PORT_D_MASK  = 8'h0F;
   localparam logic [15:0] RESET_PATTERN_DEF = 16'h0000;

   typedef enum logic [1:0] {
      IOPM_RUN,
      IOPM_RESET_DRIVE
   } iopm_state_type;
endpackage : iopm_pkg

// ==== verification/iopm_pin_model.sv ====
// Partner model: the world outside the pins and the host's boot-time look at the data bus
`timescale 1ns/100ps
`default_nettype none
module iopm_pin_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Device pins and outside levels
   input  wire logic [55:0] dev_pin_i,
   input  wire logic [55:0] dev_oe_n_i,
   input  wire logic [55:0] ext_i,
   output logic      [55:0] pin_lvl_o,
   output logic      [15:0] boot_word_o
);
   logic [15:0] last_r;
   // Released pins show the outside level, never the last driven value
   assign pin_lvl_o = (~dev_oe_n_i & dev_pin_i) | (dev_oe_n_i & ext_i);
   // Host takes the data bus word as its reset ends
   always @(posedge clk_i) if (rst_i) last_r <= pin_lvl_o[55:40];
   always @(negedge rst_i) boot_word_o <= last_r;
endmodule : iopm_pin_model
`default_nettype wire

// ==== verification/io_port_mode_config_tb.sv ====
// Testbench: register map, pin drive, data port, reset pattern and JTAG pins
`timescale 1ns/100ps
`default_nettype none
module io_port_mode_config_tb;
   logic        clk_i, rst_i, io_sel_i, rd_i, wr_i, nonmux_bus_i, reset_mode_en_i;
   logic        bus_cycle_i, host_data_oe_i, jtag_en_i, jtag_tdo_i;
   logic [7:0]  addr_i, wdata_i, rdata_o, logic_addr_in_o, v, d, m, e, oen;
   logic [15:0] reset_pattern_i, host_data_out_i, host_data_bus_o, boot_word;
   logic [3:0]  jtag_in_o;
   logic [55:0] pin_i, pin_o, pin_oe_n_o, pin_fast_slew_o, ext;
   logic [7:0]  exq[$];
   logic        rd_v = 1'b0;
   logic        slw;
   logic        addr_stb;
   logic        stb_latch;
   logic [7:0]  addr_sel;
   logic [15:0] lat_addr;
   int          ao[3] = '{iopm_pkg::PORT_B, iopm_pkg::PORT_E, iopm_pkg::PORT_G};
   int          mismatches = 0;
   int          num_checks = 0;

   // Port F feeds the logic address inputs whatever its direction bits hold
   iopm_ports u_dut (.clk_i, .rst_i, .io_sel_i, .rd_i, .wr_i, .addr_i, .wdata_i, .rdata_o,
      .nonmux_bus_i, .reset_mode_en_i, .bus_cycle_i, .reset_pattern_i, .host_data_out_i,
      .host_data_oe_i, .host_data_bus_o, .address_strobe_input_i(addr_stb), .strobe_latch_en_i(stb_latch),
      .latched_addr_i(lat_addr), .addr_in_sel_i(addr_sel), .logic_addr_in_o, .pld_oe_i(56'h0),
      .jtag_en_i, .jtag_tdo_i, .jtag_in_o, .pin_i, .pin_o, .pin_oe_n_o, .pin_fast_slew_o);

   iopm_pin_model u_model (.clk_i, .rst_i, .dev_pin_i(pin_o), .dev_oe_n_i(pin_oe_n_o), .ext_i(ext),
      .pin_lvl_o(pin_i), .boot_word_o(boot_word));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   task automatic finish_test;
      $display("Checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   // One register access; a read notes its expected data for the monitor
   task automatic acc(input logic w, input int p, input logic [7:0] ofs, input logic [7:0] dat);
      @(posedge clk_i);
      io_sel_i <= 1'b1;
      wr_i <= w;
      rd_i <= ~w;
      addr_i <= (8'(p) << 4) | ofs;
      wdata_i <= dat;
      if (!w) exq.push_back(dat);
   endtask : acc

   task automatic idle;
      @(posedge clk_i);
      io_sel_i <= 1'b0;
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
   endtask : idle

   function automatic logic [7:0] msk(input int p);
      return (p == iopm_pkg::PORT_D) ? iopm_pkg::PORT_D_MASK : 8'hFF;
   endfunction : msk

   // Read data arrives the cycle after the strobe is taken
   always @(posedge clk_i) begin
      if (rd_v) chk("rdata_o", rdata_o, exq.pop_front());
      rd_v <= io_sel_i & rd_i;
   end

   initial begin
      #(40 * 4000);
      mismatches++;
      finish_test;
   end

   initial begin
      void'($urandom(70689));
      {rst_i, io_sel_i, rd_i, wr_i, addr_i, wdata_i} = {1'b1, 19'h00000};
      {nonmux_bus_i, reset_mode_en_i, bus_cycle_i, host_data_oe_i, jtag_en_i, jtag_tdo_i} = 6'h38;
      {addr_stb, stb_latch, addr_sel, lat_addr} = 26'h0000000;
      reset_pattern_i = 16'($urandom());
      host_data_out_i = 16'h0000;
      ext = 56'({$urandom(), $urandom()});
      // ***************************************************************
      // Reset pattern, then data port
      // ***************************************************************
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk("fg oe_n in bus cycle", pin_oe_n_o[55:40], 16'hFFFF);
      @(posedge clk_i) bus_cycle_i <= 1'b0;
      @(negedge clk_i);
      chk("fg reset pattern", {pin_oe_n_o[55:40], pin_o[55:40]}, {16'h0000, reset_pattern_i});
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk("boot word", boot_word, reset_pattern_i);
      chk("fg released", pin_oe_n_o[55:40], 16'hFFFF);
      @(posedge clk_i) host_data_out_i <= 16'($urandom());
      host_data_oe_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("data port pins", {pin_oe_n_o[55:40], pin_o[55:40]}, {16'h0000, host_data_out_i});
      chk("host_data_bus_o", host_data_bus_o, host_data_out_i);
      @(posedge clk_i) nonmux_bus_i <= 1'b0;
      host_data_oe_i <= 1'b0;
      $display("Test reset pattern and data port done");
      // ***************************************************************
      // Register reset values, map, masks
      // ***************************************************************
      for (int p = 0; p < 7; p++) begin
         acc(1'b0, p, iopm_pkg::OFS_MODE_SEL, 8'h00);
         acc(1'b0, p, iopm_pkg::OFS_DIRECTION, 8'h00);
         acc(1'b0, p, iopm_pkg::OFS_DRIVE, 8'h00);
      end
      acc(1'b0, 0, 8'h0C, 8'h00);
      acc(1'b0, 7, iopm_pkg::OFS_DATA_IN, 8'h00);
      for (int p = 0; p < 7; p++) begin
         {v, d, m} = 24'($urandom());
         acc(1'b1, p, iopm_pkg::OFS_DIRECTION, v);
         acc(1'b1, p, iopm_pkg::OFS_DRIVE, d);
         acc(1'b1, p, iopm_pkg::OFS_MODE_SEL, m);
         acc(1'b0, p, iopm_pkg::OFS_DIRECTION, v & msk(p));
         acc(1'b0, p, iopm_pkg::OFS_DRIVE, d & msk(p));
         acc(1'b0, p, iopm_pkg::OFS_MODE_SEL, (p >= iopm_pkg::PORT_E) ? m : 8'h00);
      end
      idle();
      $display("Test register map done");
      // ***************************************************************
      // Output drive, open drain, slew, data in and out
      // ***************************************************************
      for (int p = 0; p < 7; p++) begin
         {v, d} = 16'($urandom());
         slw = (p == iopm_pkg::PORT_C) || (p == iopm_pkg::PORT_F);
         acc(1'b1, p, iopm_pkg::OFS_MODE_SEL, 8'h00);
         acc(1'b1, p, iopm_pkg::OFS_DIRECTION, d);
         acc(1'b1, p, iopm_pkg::OFS_DRIVE, 8'hFF);
         acc(1'b1, p, iopm_pkg::OFS_DATA_OUT, v);
         idle();
         oen = ~(d & msk(p)) | (slw ? 8'h00 : v);
         e = (~oen & v) | (oen & ext[p*8+:8]);
         chk("pin_oe_n_o", pin_oe_n_o[p*8+:8], oen);
         chk("pin_o", pin_o[p*8+:8] & ~oen, v & ~oen);
         chk("pin_fast_slew_o", pin_fast_slew_o[p*8+:8], slw ? 8'hFF : 8'h00);
         if (p != iopm_pkg::PORT_D) begin
            acc(1'b0, p, iopm_pkg::OFS_DATA_IN, e);
            acc(1'b0, p, iopm_pkg::OFS_DATA_OUT, v);
         end
      end
      for (int p = 0; p < 7; p++) acc(1'b1, p, iopm_pkg::OFS_DIRECTION, 8'h00);
      idle();
      chk("all inputs", pin_oe_n_o, {56{1'b1}});
      for (int p = 0; p < 7; p++) if (p != iopm_pkg::PORT_D) acc(1'b0, p, iopm_pkg::OFS_DATA_IN, ext[p*8+:8]);
      idle();
      $display("Test pin drive done");
      // ***************************************************************
      // Address in from port F, address out on E and G
      // ***************************************************************
      foreach (ao[i]) begin
         acc(1'b1, ao[i], iopm_pkg::OFS_MODE_SEL, 8'hFF);
         acc(1'b1, ao[i], iopm_pkg::OFS_DIRECTION, 8'hFF);
         acc(1'b1, ao[i], iopm_pkg::OFS_DRIVE, 8'h00);
      end
      lat_addr <= 16'($urandom());
      addr_sel <= 8'($urandom());
      addr_stb <= 1'b1;
      idle();
      chk("addr in live", logic_addr_in_o, ext[47:40] & addr_sel);
      chk("addr out G", {pin_oe_n_o[55:48], pin_o[55:48]}, {8'h00, lat_addr[15:8]});
      chk("addr out E", {pin_oe_n_o[39:32], pin_o[39:32]}, {8'h00, lat_addr[7:0]});
      e = ext[47:40] & addr_sel;
      @(posedge clk_i) addr_stb <= 1'b0;
      stb_latch <= 1'b1;
      addr_sel <= ~addr_sel;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("addr in latched", logic_addr_in_o, e);
      $display("Test address in and out done");
      // ***************************************************************
      // JTAG pins on port E
      // ***************************************************************
      @(posedge clk_i) jtag_en_i <= 1'b1;
      jtag_tdo_i <= 1'($urandom());
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("jtag in", jtag_in_o, {jtag_tdo_i, ext[34:32]});
      chk("jtag out", {pin_oe_n_o[35], pin_o[35]}, {1'b0, jtag_tdo_i});
      $display("Test jtag done");
      // ***************************************************************
      // Reset again with the pattern mode off
      // ***************************************************************
      @(posedge clk_i) rst_i <= 1'b1;
      reset_mode_en_i <= 1'b0;
      nonmux_bus_i <= 1'b1;
      jtag_en_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("reset no pattern", pin_oe_n_o, {56{1'b1}});
      @(posedge clk_i) rst_i <= 1'b0;
      @(negedge clk_i);
      chk("boot word no pattern", boot_word, ext[55:40]);
      acc(1'b0, iopm_pkg::PORT_G, iopm_pkg::OFS_MODE_SEL, 8'h00);
      idle();
      $display("Test second reset done");
      finish_test();
   end
endmodule : io_port_mode_config_tb
`default_nettype wire
